// file: hw/strobe_dll_pkg.sv
// constants and carrier types for the strobe phase-shift delay-locked loop
package strobe_dll_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned LOCK_REF_CYCLES = 1280;
  localparam logic [10:0] LOCK_COUNT = 11'(LOCK_REF_CYCLES);
  // reference edges between two update-enable pulses
  localparam logic [3:0] UPDATE_EDGES = 4'h8;
  // delay units that one system clock period is worth
  localparam logic [3:0] UNITS_PER_CYCLE = 4'h4;
  localparam logic [7:0] PERIOD_MAX = 8'hff;
  // fixed low-frequency shift and the step it is counted in
  localparam int unsigned FIXED_SHIFT_PS = 2500;
  localparam int unsigned STEP_PS = 50;
  localparam logic [5:0] FIXED_SETTING = 6'(FIXED_SHIFT_PS / STEP_PS);
  localparam logic [5:0] MAX_FULL = 6'h3f;
  localparam logic [5:0] MAX_HALF = 6'h1f;
  localparam logic signed [6:0] OFF_MAX_FULL = 7'sh3f;
  localparam logic signed [6:0] OFF_MIN_FULL = -7'sh40;
  localparam logic signed [6:0] OFF_MAX_HALF = 7'sh1f;
  localparam logic signed [6:0] OFF_MIN_HALF = -7'sh20;
  localparam logic [2:0] MODE_FIRST_HALF = 3'h4;
  localparam logic [2:0] MODE_LAST = 3'h6;
  localparam logic [5:0] RESET_SETTING = 6'h00;

  typedef enum logic [1:0] {
    LOOP_HOLD = 2'b00,
    LOOP_ACQUIRE = 2'b01,
    LOOP_LOCKED = 2'b11
  } loop_state_t;

  typedef enum logic [1:0] {
    REF_PLL_TB = 2'h0,
    REF_PLL_LR = 2'h1,
    REF_PIN_TB = 2'h2,
    REF_PIN_LR = 2'h3
  } ref_sel_t;

  // dynamic offset request for one side pair
  typedef struct packed {
    logic [5:0] amount;
    logic add_not_sub;
  } offset_req_t;

  // strobe routing enables toward the io cells
  typedef struct packed {
    logic bypass;
    logic capture;
    logic to_core;
    logic cq_negedge_only;
  } strobe_route_t;

  // per-strobe delay logic bundle for one side pair
  typedef struct packed {
    logic [5:0] delay;
    logic [6:0] offset;
    logic update;
  } side_setting_t;

  typedef struct packed {
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;
    logic [4:0] pin_lvl;
    logic ref_prev;
    loop_state_t state;
    logic [2:0] mode;
    logic [7:0] period_cnt;
    logic [7:0] period;
    logic [5:0] setting;
    logic [10:0] lock_cnt;
    logic [3:0] upd_cnt;
    logic update;
    side_setting_t side_tb;
    side_setting_t side_lr;
    logic [5:0] core_delay;
    strobe_route_t route;
  } dll_state_t;

endpackage : strobe_dll_pkg

// file: hw/gray_setting_step.sv
// one saturating up/down step of a gray-coded setting word
`timescale 1ns/100ps
module gray_setting_step (
  // current word and request
  input wire logic [5:0] i_gray,
  input wire logic i_step,
  input wire logic i_up,
  input wire logic [5:0] i_max,
  // next word
  output logic [5:0] o_gray
);
  logic [5:0] bin;
  logic [5:0] next_bin;

  always_comb begin
    bin[5] = i_gray[5];
    for (int i = 4; i >= 0; i--) begin
      bin[i] = bin[i + 1] ^ i_gray[i];
    end
    next_bin = bin;
    if (bin > i_max) begin
      next_bin = i_max;
    end else if (i_step) begin
      if (i_up && bin != i_max) begin
        next_bin = bin + 6'h01;
      end else if (!i_up && bin != 6'h00) begin
        next_bin = bin - 6'h01;
      end
    end
    o_gray = next_bin ^ (next_bin >> 1);
  end
endmodule : gray_setting_step

// file: hw/strobe_phase_shift_dll.sv
// delay-locked loop that turns a reference period into strobe delay settings
`timescale 1ns/100ps
module strobe_phase_shift_dll (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // loop resets
  input wire logic i_core_reset,
  input wire logic i_pin_reset,
  // reference clock sources
  input wire logic [3:0] i_ref_src,
  input wire strobe_dll_pkg::ref_sel_t i_ref_sel,
  // configuration
  input wire logic [2:0] i_mode,
  input wire logic i_low_freq,
  input wire logic i_zero_shift,
  input wire logic i_io_resync_used,
  input wire logic i_qdr_cq,
  // dynamic offsets per side pair
  input wire strobe_dll_pkg::offset_req_t i_offset_tb,
  input wire strobe_dll_pkg::offset_req_t i_offset_lr,
  // per-strobe delay logic
  output strobe_dll_pkg::side_setting_t o_side_tb,
  output strobe_dll_pkg::side_setting_t o_side_lr,
  // core and leveling
  output logic [5:0] o_core_delay,
  output logic o_locked,
  output strobe_dll_pkg::loop_state_t o_state,
  // strobe routing
  output strobe_dll_pkg::strobe_route_t o_route
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [5:0] gray_to_bin(input logic [5:0] g);
    logic [5:0] b;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  function automatic logic [4:0] chains_of(input logic [2:0] m);
    logic [4:0] n;
    case (m)
      3'h0: n = 5'h10;
      3'h1, 3'h4: n = 5'h0c;
      3'h2, 3'h5: n = 5'h0a;
      default: n = 5'h08;
    endcase
    return n;
  endfunction : chains_of

  function automatic logic is_half(input logic [2:0] m);
    return m >= strobe_dll_pkg::MODE_FIRST_HALF;
  endfunction : is_half

  // clamp and gray-code a signed offset
  function automatic logic [6:0] offset_word(
    input strobe_dll_pkg::offset_req_t r,
    input logic [2:0] m
  );
    logic signed [6:0] v;
    logic signed [6:0] lo;
    logic signed [6:0] hi;
    logic [6:0] u;
    v = r.add_not_sub ? $signed({1'b0, r.amount})
                      : -$signed({1'b0, r.amount});
    lo = is_half(m) ? strobe_dll_pkg::OFF_MIN_HALF
                    : strobe_dll_pkg::OFF_MIN_FULL;
    hi = is_half(m) ? strobe_dll_pkg::OFF_MAX_HALF
                    : strobe_dll_pkg::OFF_MAX_FULL;
    if (v < lo) begin
      v = lo;
    end
    if (v > hi) begin
      v = hi;
    end
    u = v;
    return u ^ (u >> 1);
  endfunction : offset_word

  ////////////////////////////////////////////////////////////////////////////
  // state

  strobe_dll_pkg::dll_state_t st;
  strobe_dll_pkg::dll_state_t next_st;

  logic [5:0] mode_max;
  logic [5:0] stepped;
  logic [5:0] setting_bin;
  logic [10:0] chain_units;
  logic [11:0] target_units;
  logic ref_level;
  logic ref_rise;
  logic soft_reset;
  logic step;
  logic step_up;
  logic [5:0] applied;
  logic [2:0] mode_ok;

  ////////////////////////////////////////////////////////////////////////////
  // comparator and counter

  assign mode_max = is_half(st.mode) ? strobe_dll_pkg::MAX_HALF
                                     : strobe_dll_pkg::MAX_FULL;
  assign setting_bin = gray_to_bin(st.setting);
  assign chain_units = 11'(setting_bin) * 11'(chains_of(st.mode));
  assign target_units = 12'(st.period) *
                        12'(strobe_dll_pkg::UNITS_PER_CYCLE);

  gray_setting_step u_step (
    .i_gray(st.setting),
    .i_step(step),
    .i_up(step_up),
    .i_max(mode_max),
    .o_gray(stepped)
  );

  always_comb begin
    ref_level = st.pin_lvl[i_ref_sel];
    ref_rise = ref_level && !st.ref_prev;
    soft_reset = i_core_reset || st.pin_lvl[4];
    step_up = {1'b0, chain_units} < target_units;
    step = ref_rise && st.state != strobe_dll_pkg::LOOP_HOLD &&
           ({1'b0, chain_units} != target_units) && st.period != 8'h00;
    mode_ok = (i_mode > strobe_dll_pkg::MODE_LAST) ? strobe_dll_pkg::MODE_LAST
                                                  : i_mode;
  end

  always_comb begin
    if (i_low_freq) begin
      applied = (strobe_dll_pkg::FIXED_SETTING > mode_max) ? mode_max
                : strobe_dll_pkg::FIXED_SETTING;
      applied = applied ^ (applied >> 1);
    end else begin
      applied = st.setting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // three-stage pin synchronisers
    next_st.pin_s1 = {i_pin_reset, i_ref_src};
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    for (int i = 0; i < 5; i++) begin
      if (st.pin_s2[i] == st.pin_s3[i]) begin
        next_st.pin_lvl[i] = st.pin_s3[i];
      end
    end
    next_st.ref_prev = ref_level;
    next_st.update = 1'b0;

    // period measurement in system clocks
    if (ref_rise) begin
      next_st.period = st.period_cnt;
      next_st.period_cnt = 8'h01;
    end else if (st.period_cnt != strobe_dll_pkg::PERIOD_MAX) begin
      next_st.period_cnt = st.period_cnt + 8'h01;
    end

    case (st.state)
      strobe_dll_pkg::LOOP_HOLD: begin
        next_st.state = strobe_dll_pkg::LOOP_ACQUIRE;
      end
      strobe_dll_pkg::LOOP_ACQUIRE: begin
        if (ref_rise) begin
          next_st.lock_cnt = st.lock_cnt + 11'h001;
          if (st.lock_cnt + 11'h001 == strobe_dll_pkg::LOCK_COUNT) begin
            next_st.state = strobe_dll_pkg::LOOP_LOCKED;
          end
        end
      end
      strobe_dll_pkg::LOOP_LOCKED: begin
        next_st.state = strobe_dll_pkg::LOOP_LOCKED;
      end
      default: begin
        next_st.state = strobe_dll_pkg::LOOP_HOLD;
      end
    endcase

    next_st.setting = stepped;
    if (is_half(st.mode)) begin
      next_st.setting[5] = 1'b0;
    end

    if (ref_rise) begin
      if (st.upd_cnt == strobe_dll_pkg::UPDATE_EDGES - 4'h1) begin
        next_st.upd_cnt = 4'h0;
        next_st.update = 1'b1;
      end else begin
        next_st.upd_cnt = st.upd_cnt + 4'h1;
      end
    end

    if (st.update) begin
      next_st.side_tb.delay = applied;
      next_st.side_lr.delay = applied;
      next_st.side_tb.offset = offset_word(i_offset_tb, st.mode);
      next_st.side_lr.offset = offset_word(i_offset_lr, st.mode);
      next_st.core_delay = applied;
    end
    next_st.side_tb.update = st.update;
    next_st.side_lr.update = st.update;

    next_st.route.bypass = i_zero_shift;
    next_st.route.capture = !i_zero_shift && !i_qdr_cq;
    next_st.route.to_core = !i_zero_shift && !i_io_resync_used && !i_qdr_cq;
    next_st.route.cq_negedge_only = !i_zero_shift && i_qdr_cq;

    if (soft_reset) begin
      next_st.state = strobe_dll_pkg::LOOP_HOLD;
      next_st.mode = mode_ok;
      next_st.setting = strobe_dll_pkg::RESET_SETTING;
      next_st.lock_cnt = 11'h000;
      next_st.upd_cnt = 4'h0;
      next_st.period = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_side_tb = st.side_tb;
  assign o_side_lr = st.side_lr;
  assign o_core_delay = st.core_delay;
  assign o_locked = st.state == strobe_dll_pkg::LOOP_LOCKED;
  assign o_state = st.state;
  assign o_route = st.route;

endmodule : strobe_phase_shift_dll

// file: test/strobe_dll_chk.sv
// port checker for the strobe phase-shift loop
`timescale 1ns/100ps
module strobe_dll_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // watched inputs
  input wire logic i_core_reset,
  input wire logic i_pin_reset,
  input wire logic [2:0] i_mode,
  input wire logic i_zero_shift,
  input wire logic i_qdr_cq,
  // watched outputs
  input wire strobe_dll_pkg::side_setting_t o_side_tb,
  input wire strobe_dll_pkg::side_setting_t o_side_lr,
  input wire logic [5:0] o_core_delay,
  input wire logic o_locked,
  input wire strobe_dll_pkg::loop_state_t o_state,
  input wire strobe_dll_pkg::strobe_route_t o_route
);
  // longest acquire the bench allows, 12-clock reference
  localparam int LOCK_MAX = 1280 * 12 + 24;
  logic [15:0] acq;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acq <= 16'h0000;
    end else begin
      acq <= (o_state == 2'b01) ? acq + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////
  gray_step_a: assert property (
    o_locked && $past(o_locked) && $changed(o_core_delay)
    |-> $onehot(o_core_delay ^ $past(o_core_delay)))
    else $error("delay word jumped more than one bit");
  same_sides_a: assert property (
    o_side_tb.delay == o_side_lr.delay && o_core_delay == o_side_tb.delay)
    else $error("side delays differ");
  half_msb_a: assert property (
    o_side_tb.update && i_mode > 3'h3 && $past(i_mode) > 3'h3 &&
    $past(i_mode, 2) > 3'h3 |-> !o_side_tb.delay[5])
    else $error("top delay bit set in a five-bit mode");
  lock_bound_a: assert property (
    o_state == 2'b01 |-> acq < LOCK_MAX)
    else $error("acquire ran past the lock bound");
  soft_hold_a: assert property (
    i_core_reset |=> o_state == 2'b00 && !o_locked)
    else $error("core reset did not hold the loop");
  pin_hold_a: assert property (
    i_pin_reset [*6] |=> o_state == 2'b00)
    else $error("pin reset did not hold the loop");
  zero_bypass_a: assert property (
    i_zero_shift |=> o_route == 4'h8)
    else $error("zero shift not bypassed");
  qdr_route_a: assert property (
    !i_zero_shift && i_qdr_cq |=> o_route == 4'h1)
    else $error("complementary clock routed elsewhere");
  lock_seen_c: cover property ($rose(o_locked));
  sat_c: cover property (o_side_tb.update && o_core_delay == 6'h10);
  bypass_c: cover property (o_route.bypass);
endmodule : strobe_dll_chk
bind strobe_phase_shift_dll strobe_dll_chk u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_core_reset(i_core_reset),
  .i_pin_reset(i_pin_reset), .i_mode(i_mode), .i_zero_shift(i_zero_shift),
  .i_qdr_cq(i_qdr_cq), .o_side_tb(o_side_tb), .o_side_lr(o_side_lr),
  .o_core_delay(o_core_delay), .o_locked(o_locked), .o_state(o_state),
  .o_route(o_route));

// file: test/ref_source_model.sv
// reference clock sources feeding the loop
`timescale 1ns/100ps
module ref_source_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // chosen source and half period in clocks
  input wire logic [1:0] i_sel,
  input wire logic [7:0] i_half,
  // source levels
  output logic [3:0] o_ref
);
  logic [7:0] cnt;
  logic lvl;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 8'h00;
      lvl <= 1'b0;
      o_ref <= 4'h0;
    end else begin
      // one steady frequency on the chosen source
      cnt <= (cnt + 8'h01 >= i_half) ? 8'h00 : cnt + 8'h01;
      if (cnt + 8'h01 >= i_half) begin
        lvl <= !lvl;
      end
      // unchosen sources toggle every clock
      o_ref <= ~o_ref;
      o_ref[i_sel] <= lvl;
    end
  end
endmodule : ref_source_model

// file: test/strobe_phase_shift_dll_tb_top.sv
// self-checking bench for the strobe phase-shift loop
`timescale 1ns/100ps
module strobe_phase_shift_dll_tb_top;
  localparam int CHAINS [7] = '{16, 12, 10, 8, 12, 10, 8};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic core_rst = 1'b0;
  logic pin_rst = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] half = 8'h06;
  logic [2:0] mode = 3'h0;
  logic low_freq = 1'b0;
  logic zero = 1'b0;
  logic resync = 1'b0;
  logic qdr = 1'b0;
  strobe_dll_pkg::offset_req_t off_tb = 7'h00;
  strobe_dll_pkg::offset_req_t off_lr = 7'h00;
  logic [3:0] ref_src;
  strobe_dll_pkg::side_setting_t o_side_tb;
  strobe_dll_pkg::side_setting_t o_side_lr;
  logic [5:0] o_core_delay;
  logic o_locked;
  strobe_dll_pkg::strobe_route_t o_route;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  ref_source_model u_ref (.i_clk(clk), .i_rstn(rstn), .i_sel(sel),
    .i_half(half), .o_ref(ref_src));
  strobe_phase_shift_dll u_dut (.i_clk(clk), .i_rstn(rstn),
    .i_core_reset(core_rst), .i_pin_reset(pin_rst), .i_ref_src(ref_src),
    .i_ref_sel(strobe_dll_pkg::ref_sel_t'(sel)), .i_mode(mode),
    .i_low_freq(low_freq), .i_zero_shift(zero), .i_io_resync_used(resync),
    .i_qdr_cq(qdr), .i_offset_tb(off_tb), .i_offset_lr(off_lr),
    .o_side_tb(o_side_tb), .o_side_lr(o_side_lr),
    .o_core_delay(o_core_delay), .o_locked(o_locked), .o_state(),
    .o_route(o_route));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] to_bin(input logic [6:0] g);
    logic [6:0] b;
    b[6] = g[6];
    for (int i = 5; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : to_bin
  function automatic logic [6:0] exp_off(
    input strobe_dll_pkg::offset_req_t r, input logic [2:0] m);
    logic signed [7:0] v;
    v = r.add_not_sub ? {2'b00, r.amount} : -{2'b00, r.amount};
    if (m > 3'h3 && v > 8'sd31) begin
      v = 8'sd31;
    end
    if (m > 3'h3 && v < -8'sd32) begin
      v = -8'sd32;
    end
    return v[6:0] ^ (v[6:0] >> 1);
  endfunction : exp_off
  task automatic check(input string what, input logic [6:0] exp,
    input logic [6:0] got);
    tests_run++;
    if (exp !== got) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic phase(input int m, input int h, input logic lf,
    input int rises);
    int lo;
    int hi;
    int mx;
    logic [6:0] got;
    @(posedge clk);
    core_rst <= 1'b1;
    mode <= 3'(m);
    half <= 8'(h);
    low_freq <= lf;
    sel <= 2'($urandom);
    off_tb <= 7'($urandom);
    off_lr <= 7'($urandom);
    repeat (3) @(posedge clk);
    core_rst <= 1'b0;
    repeat (rises * 2 * h) @(posedge clk);
    @(negedge clk);
    mx = m > 3 ? 31 : 63;
    lo = lf ? 50 : 8 * h / CHAINS[m];
    hi = lf ? 50 : (8 * h + CHAINS[m] - 1) / CHAINS[m];
    lo = lo > mx ? mx : lo;
    hi = hi > mx ? mx : hi;
    got = to_bin({1'b0, o_core_delay});
    check("delay", 7'(lo), got === 7'(hi) ? 7'(lo) : got);
    check("offset tb", exp_off(off_tb, 3'(m)), o_side_tb.offset);
    check("offset lr", exp_off(off_lr, 3'(m)), o_side_lr.offset);
  endtask : phase
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    logic [3:0] exp_r;
    int n;
    void'($urandom(32'hbec71e79));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {zero, qdr, resync} <= 3'(i);
      repeat (2) @(posedge clk);
      @(negedge clk);
      exp_r = zero ? 4'h8 : qdr ? 4'h1 : {2'b01, !resync, 1'b0};
      check("route", {3'h0, exp_r}, {3'h0, o_route});
    end
    for (int m = 0; m < 7; m++) begin
      phase(m, 6, 1'b0, 40);
    end
    phase(3, 70, 1'b0, 80);
    phase(4, 50, 1'b0, 40);
    phase(1, 6, 1'b1, 24);
    phase(5, 6, 1'b1, 24);
    @(posedge clk);
    mode <= 3'h2;
    half <= 8'h06;
    low_freq <= 1'b0;
    pin_rst <= 1'b1;
    repeat (8) @(posedge clk);
    pin_rst <= 1'b0;
    n = 0;
    @(negedge clk);
    while (o_locked !== 1'b1 && n < 16000) begin
      @(negedge clk);
      n++;
    end
    check("lock time", 7'h1, {6'h00, n >= 15340 && n <= 15390});
    repeat (600) @(negedge clk);
    n = int'(to_bin({1'b0, o_core_delay}));
    check("locked delay", 7'h4, n == 5 ? 7'h4 : 7'(n));
    conclude();
  end
endmodule : strobe_phase_shift_dll_tb_top
